// ---- lvdw_pkg.sv ----
// Package for the supply monitor and wake-up block: register map, field layout, timing.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
package lvdw_pkg;

  // Register byte addresses.
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_IRQ      = 4'h4;
  localparam logic [3:0] ADDR_CORE     = 4'h8;
  localparam logic [3:0] ADDR_STACKTOP = 4'hc;

  // Control register fields.
  localparam int THR_LSB  = 0;
  localparam int THR_MSB  = 2;
  localparam int EN_BIT   = 4;
  localparam int FLAG_BIT = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h17;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // Interrupt register fields.
  localparam int IRQF_BIT   = 0;
  localparam int IRQE_BIT   = 1;
  localparam int GROUPF_BIT = 2;
  localparam int GROUPE_BIT = 3;
  localparam int GIE_BIT    = 4;

  // Core command register fields (write only, pulses).
  localparam int CMD_RETURN_FROM_IRQ  = 0;
  localparam int CMD_RET   = 1;
  localparam int CMD_SLEEP = 2;
  localparam int CMD_IDLE  = 3;

  // Request flag delay after the detect flag rises.
  localparam int IRQ_DELAY_NS  = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int IRQ_DELAY_CYC = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W         = 8;

  localparam logic [12:0] IRQ_VECTOR = 13'h0010;
  localparam int PC_W = 13;

  typedef enum logic [1:0] {
    LVDW_RUN,
    LVDW_SLEEP,
    LVDW_IDLE
  } lvdw_pmode_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [31:0] writedata;
  } lvdw_req_t;

endpackage : lvdw_pkg

// ---- lvdw_delay.sv ----
// Qualification delay: a pulse once the detect level has stayed high for the set count.
// Assumes a synchronised level input on the system clock.
module lvdw_delay (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic level_in,
  output logic      fire_out
);
  logic [lvdw_pkg::DLY_W-1:0] cnt_r;

  // A dip restarts the count, so a supply hovering at the threshold needs a full quiet period.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r    <= '0;
      fire_out <= 1'b0;
    end else begin
      fire_out <= 1'b0;
      if (!level_in) begin
        cnt_r <= '0;
      end else if (cnt_r != lvdw_pkg::DLY_W'(lvdw_pkg::IRQ_DELAY_CYC)) begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == lvdw_pkg::DLY_W'(lvdw_pkg::IRQ_DELAY_CYC - 1)) begin
          fire_out <= 1'b1;
        end
      end
    end
  end
endmodule : lvdw_delay

// ---- lvdw_top.sv ----
// Supply monitor with low-voltage interrupt, grouped request and wake-up control.
// Assumes an analog comparator output that is asynchronous and an Avalon-MM master.
//
// Contract
// - Any request flag rising wakes the core
// - Wake-up ignores the per-interrupt enables
// - Flags stay set until serviced or cleared
// - Servicing clears only the group flag
// - Entry pushes only the program counter
// - Return-from-irq sets global enable; plain doesn't
// - Bit 4 enables the detector
// - Bit 5 reads the detect level
// - Three-bit threshold, all codes 3.6V
// - Bits 7, 6, 3 read zero
// - Detector runs while powered down
// - Request flag set after fixed delay
// - Detect level may toggle repeatedly
// - Flag set in sleep wakes, unless preset
// - Reference enabled together with detector
// - Low-voltage request belongs to group
// - Taken only with both enables set
//
// The address map and the Avalon-MM register port are this design's own decisions.
module lvdw_top (
  input  wire logic                       sys_clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       avs_read_in,
  input  wire logic                       avs_write_in,
  input  wire logic [3:0]                 avs_address_in,
  input  wire logic [31:0]                avs_writedata_in,
  output logic [31:0]                     avs_readdata_out,
  output logic                            avs_waitrequest_out,
  input  wire logic                       comp_low_in,
  input  wire logic [lvdw_pkg::PC_W-1:0]  core_pc_in,
  input  wire logic                       core_ack_in,
  output logic                            comp_enable_out,
  output logic                            ref_enable_out,
  output logic                            wake_out,
  output logic                            irq_take_out,
  output logic [lvdw_pkg::PC_W-1:0]       irq_vector_out,
  output logic [1:0]                      power_mode_out
);

  lvdw_pkg::lvdw_req_t req;
  assign req = '{read: avs_read_in, write: avs_write_in,
                 address: avs_address_in, writedata: avs_writedata_in};

  logic [7:0]                ctrl_r;
  logic                      sync1_r;
  logic                      sync2_r;
  logic                      fire;
  logic                      irqf_r;
  logic                      irqe_r;
  logic                      groupf_r;
  logic                      groupe_r;
  logic                      gie_r;
  logic                      groupf_prev_r;
  logic                      irqf_prev_r;
  logic [lvdw_pkg::PC_W-1:0] stack_r;
  logic                      ack_pend_r;
  lvdw_pkg::lvdw_pmode_t     mode_r;

  // One bus access takes two cycles: the request stalls for one cycle, then completes.
  logic ack_now;
  assign ack_now = (req.read || req.write) && ack_pend_r;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction : hit

  logic wr_ctrl;
  logic wr_irq;
  logic wr_cmd;
  assign wr_ctrl = ack_now && req.write && hit(req.address, lvdw_pkg::ADDR_CTRL);
  assign wr_irq  = ack_now && req.write && hit(req.address, lvdw_pkg::ADDR_IRQ);
  assign wr_cmd  = ack_now && req.write && hit(req.address, lvdw_pkg::ADDR_CORE);

  logic cmd_return_from_irq;
  logic cmd_ret;
  logic cmd_sleep;
  logic cmd_idle;
  assign cmd_return_from_irq  = wr_cmd && req.writedata[lvdw_pkg::CMD_RETURN_FROM_IRQ];
  assign cmd_ret   = wr_cmd && req.writedata[lvdw_pkg::CMD_RET];
  assign cmd_sleep = wr_cmd && req.writedata[lvdw_pkg::CMD_SLEEP];
  assign cmd_idle  = wr_cmd && req.writedata[lvdw_pkg::CMD_IDLE];

  // Read decode; an address that matches none of these reads as zero.
  logic rd_ctrl;
  logic rd_irq;
  logic rd_stack;
  assign rd_ctrl  = hit(req.address, lvdw_pkg::ADDR_CTRL);
  assign rd_irq   = hit(req.address, lvdw_pkg::ADDR_IRQ);
  assign rd_stack = hit(req.address, lvdw_pkg::ADDR_STACKTOP);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_pend_r <= 1'b0;
    end else begin
      ack_pend_r <= (req.read || req.write) && !ack_pend_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((req.read || req.write) && !ack_pend_r);
    end
  end

  // Enable and threshold are writable; the flag and unused bits are not stored.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r <= lvdw_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= req.writedata[7:0] & lvdw_pkg::CTRL_WMASK;
    end
  end

  // The comparator and its reference follow the enable bit in every power mode.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      comp_enable_out <= 1'b0;
    end else begin
      comp_enable_out <= ctrl_r[lvdw_pkg::EN_BIT];
    end
  end

  // The reference has no bit of its own, so it is powered whenever the detector is.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_enable_out <= 1'b0;
    end else begin
      ref_enable_out <= ctrl_r[lvdw_pkg::EN_BIT];
    end
  end

  // Only sync2_r is read past this point.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= comp_low_in && ctrl_r[lvdw_pkg::EN_BIT];
      sync2_r <= sync1_r;
    end
  end

  // The delay restarts on every drop, so hovering near the threshold is harmless.
  lvdw_delay u_delay (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .level_in   (sync2_r),
    .fire_out   (fire)
  );

  logic take;
  assign take = gie_r && groupe_r && groupf_r && irqe_r && !irq_take_out;

  // Source flag: set by the delayed detect, cleared only by software; set beats clear.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irqf_r <= 1'b0;
    end else if (fire) begin
      irqf_r <= 1'b1;
    end else if (wr_irq) begin
      irqf_r <= req.writedata[lvdw_pkg::IRQF_BIT];
    end
  end

  // Group flag follows the source rising and clears on servicing, not on the source.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      groupf_r <= 1'b0;
    end else if (fire) begin
      groupf_r <= 1'b1;
    end else if (take) begin
      groupf_r <= 1'b0;
    end else if (wr_irq) begin
      groupf_r <= req.writedata[lvdw_pkg::GROUPF_BIT];
    end
  end

  // Enables gate only servicing; they never touch the flags or the wake path.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irqe_r <= 1'b0;
    end else if (wr_irq) begin
      irqe_r <= req.writedata[lvdw_pkg::IRQE_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      groupe_r <= 1'b0;
    end else if (wr_irq) begin
      groupe_r <= req.writedata[lvdw_pkg::GROUPE_BIT];
    end
  end

  // Global enable: cleared on entry, set by return-from-irq, held low by plain return.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gie_r <= 1'b0;
    end else if (take) begin
      gie_r <= 1'b0;
    end else if (cmd_return_from_irq) begin
      gie_r <= 1'b1;
    end else if (cmd_ret) begin
      gie_r <= 1'b0;
    end else if (wr_irq) begin
      gie_r <= req.writedata[lvdw_pkg::GIE_BIT];
    end
  end

  // Only the program counter is saved; no other core state is captured.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_r <= '0;
    end else if (take) begin
      stack_r <= core_pc_in;
    end
  end

  // Entry stays raised until the core acknowledges, so a slow push cannot miss it.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_take_out <= 1'b0;
    end else if (take) begin
      irq_take_out <= 1'b1;
    end else if (core_ack_in) begin
      irq_take_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_vector_out <= '0;
    end else if (take) begin
      irq_vector_out <= lvdw_pkg::IRQ_VECTOR;
    end
  end

  // Wake is an edge on any request flag, enables not consulted.
  logic flag_rise;
  assign flag_rise = (irqf_r && !irqf_prev_r) || (groupf_r && !groupf_prev_r);

  // Both copies reset low, the idle level of the flags, so no false edge follows reset.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irqf_prev_r <= 1'b0;
    end else begin
      irqf_prev_r <= irqf_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      groupf_prev_r <= 1'b0;
    end else begin
      groupf_prev_r <= groupf_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_r <= lvdw_pkg::LVDW_RUN;
    end else begin
      case (mode_r)
        lvdw_pkg::LVDW_RUN: begin
          if (cmd_sleep) begin
            mode_r <= lvdw_pkg::LVDW_SLEEP;
          end else if (cmd_idle) begin
            mode_r <= lvdw_pkg::LVDW_IDLE;
          end
        end
        lvdw_pkg::LVDW_SLEEP: begin
          if (flag_rise) begin
            mode_r <= lvdw_pkg::LVDW_RUN;
          end
        end
        lvdw_pkg::LVDW_IDLE: begin
          if (flag_rise) begin
            mode_r <= lvdw_pkg::LVDW_RUN;
          end
        end
        // The spare code can only come from an upset; fall back to running.
        default: begin
          mode_r <= lvdw_pkg::LVDW_RUN;
        end
      endcase
    end
  end

  // Wake and the visible mode are both taken from mode_r on the same edge.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= flag_rise && (mode_r != lvdw_pkg::LVDW_RUN);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_mode_out <= 2'h0;
    end else begin
      power_mode_out <= mode_r;
    end
  end

  // Read data is registered with the stall cycle, so it stands when waitrequest drops.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h0;
    end else begin
      avs_readdata_out <= 32'h0;
      if (rd_ctrl) begin
        avs_readdata_out[7:0] <= {2'h0, sync2_r, ctrl_r[4:0]};
      end else if (rd_irq) begin
        avs_readdata_out[4:0] <= {gie_r, groupe_r, groupf_r, irqe_r, irqf_r};
      end else if (rd_stack) begin
        avs_readdata_out[lvdw_pkg::PC_W-1:0] <= stack_r;
      end
    end
  end

endmodule : lvdw_top

// ---- lvdw_top_chk.sv ----
// Checker for the supply monitor top: bus handshake, enables, wake and entry.
// Assumes it is bound onto lvdw_top and sees only that module's ports.
module lvdw_top_chk (
  input wire logic                      sys_clk_in,
  input wire logic                      reset_n_in,
  input wire logic                      avs_read_in,
  input wire logic                      avs_write_in,
  input wire logic [3:0]                avs_address_in,
  input wire logic [31:0]               avs_writedata_in,
  input wire logic [31:0]               avs_readdata_out,
  input wire logic                      avs_waitrequest_out,
  input wire logic                      comp_low_in,
  input wire logic [lvdw_pkg::PC_W-1:0] core_pc_in,
  input wire logic                      core_ack_in,
  input wire logic                      comp_enable_out,
  input wire logic                      ref_enable_out,
  input wire logic                      wake_out,
  input wire logic                      irq_take_out,
  input wire logic [lvdw_pkg::PC_W-1:0] irq_vector_out,
  input wire logic [1:0]                power_mode_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_ref_with_en: assert property (ref_enable_out == comp_enable_out)
    else $error("reference enable differs from detector enable");
  chk_en_after_write: assert property ($rose(comp_enable_out) |->
    ($past(avs_write_in) || $past(avs_write_in, 2))) else $error("enable rose without a write");
  chk_ctrl_unused_zero: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in == lvdw_pkg::ADDR_CTRL |-> (avs_readdata_out & 32'hffffffc8) == 32'h0)
    else $error("unused control bits read nonzero");
  chk_wait_one_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  chk_wake_from_low: assert property (wake_out |-> power_mode_out != 2'h0)
    else $error("wake pulse outside sleep or idle");
  chk_wake_single: assert property (wake_out |=> !wake_out)
    else $error("wake pulse longer than one cycle");
  chk_vector_held: assert property (irq_take_out |-> irq_vector_out == lvdw_pkg::IRQ_VECTOR)
    else $error("wrong vector during entry");
  chk_take_until_ack: assert property (irq_take_out && !core_ack_in |=> irq_take_out)
    else $error("entry dropped before acknowledge");
  chk_ack_clears_take: assert property (irq_take_out && core_ack_in |=> !irq_take_out)
    else $error("entry not cleared by acknowledge");
endmodule : lvdw_top_chk

// ---- lvdw_supply.sv ----
// Far-side model: the analog supply comparator and the core's entry acknowledge.
// Assumes the bench sets the virtual supply level; one system clock.
module lvdw_supply (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic supply_low_in,
  input  wire logic comp_enable_in,
  input  wire logic ref_enable_in,
  input  wire logic irq_take_in,
  output logic      comp_low_out,
  output logic      core_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ack_dly_r;

  // An unpowered comparator gives no trustworthy level, so it chatters every cycle.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      comp_low_out <= 1'b0;
    end else if (comp_enable_in && ref_enable_in) begin
      comp_low_out <= supply_low_in;
    end else begin
      comp_low_out <= ~comp_low_out;
    end
  end

  // The core needs two cycles to finish its push before it acknowledges.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_dly_r <= 2'h0;
    end else begin
      ack_dly_r <= {ack_dly_r[0], irq_take_in};
    end
  end
  assign core_ack_out = ack_dly_r[1];
endmodule : lvdw_supply

// ---- lvdw_top_test.sv ----
// Self-checking bench for lvdw_top: register access, detection, entry and wake.
// Assumes lvdw_supply stands in for the comparator and the core.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module lvdw_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in = 1'b0, reset_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic        avs_waitrequest_out, comp_low_in, core_ack_in, supply_low = 1'b0;
  logic        comp_enable_out, ref_enable_out, wake_out, irq_take_out;
  logic [12:0] core_pc_in = 13'h0abc, irq_vector_out;
  logic [1:0]  power_mode_out;
  int          fail_count = 0, cmp_count = 0, cyc = 0, i;

  lvdw_top lvdw_top_i (.sys_clk_in, .reset_n_in, .avs_read_in, .avs_write_in, .avs_address_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .comp_low_in, .core_pc_in,
    .core_ack_in, .comp_enable_out, .ref_enable_out, .wake_out, .irq_take_out,
    .irq_vector_out, .power_mode_out);
  lvdw_supply lvdw_supply_i (.sys_clk_in, .reset_n_in, .supply_low_in(supply_low),
    .comp_enable_in(comp_enable_out), .ref_enable_in(ref_enable_out),
    .irq_take_in(irq_take_out), .comp_low_out(comp_low_in), .core_ack_out(core_ack_in));

  always #2.5 sys_clk_in = ~sys_clk_in;

  // No local limit on the wait: only the cycle ceiling ends a stalled access.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    avs_write_in <= w;
    avs_read_in <= ~w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 4'h0, 32'hff);
    // The comparator chatters until it is powered, so the detect bit is read only later.
    repeat (4) @(posedge sys_clk_in);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h17)
    `CHK(ref_enable_out, 1'b1)
    bus(1'b1, 4'h0, 32'h0);
    repeat (2) @(posedge sys_clk_in);
    `CHK(comp_enable_out, 1'b0)
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, 32'h10 | i);
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h10 | i)
    end
    bus(1'b1, 4'h2, 32'hff);
    bus(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(q, 32'h0)
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      supply_low <= 1'b1;
      repeat (100) @(posedge sys_clk_in);
      supply_low <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
    end
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0)
    supply_low <= 1'b1;
    repeat (150) @(posedge sys_clk_in);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h37)
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0)
    repeat (80) @(posedge sys_clk_in);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h5)
    supply_low <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h17)
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h5)
    $display("test detection done");
    bus(1'b1, 4'h4, 32'h0f);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0f)
    `CHK(irq_take_out, 1'b0)
    bus(1'b1, 4'h4, 32'h1f);
    for (i = 0; i < 50 && irq_take_out !== 1'b1; i++) @(posedge sys_clk_in);
    `CHK(irq_take_out, 1'b1)
    `CHK(irq_vector_out, lvdw_pkg::IRQ_VECTOR)
    for (i = 0; i < 50 && irq_take_out !== 1'b0; i++) @(posedge sys_clk_in);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0b)
    bus(1'b0, 4'hc, 32'h0);
    `CHK(q, 32'h0abc)
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h1b)
    bus(1'b1, 4'h4, 32'h0b);
    bus(1'b1, 4'h8, 32'h2);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0b)
    $display("test entry done");
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'h4);
    // The mode output trails the mode register by one edge.
    repeat (2) @(posedge sys_clk_in);
    `CHK(power_mode_out, 2'h1)
    supply_low <= 1'b1;
    for (i = 0; i < 300 && wake_out !== 1'b1; i++) @(posedge sys_clk_in);
    `CHK(wake_out, 1'b1)
    @(posedge sys_clk_in);
    `CHK(power_mode_out, 2'h0)
    supply_low <= 1'b0;
    bus(1'b1, 4'h8, 32'h8);
    repeat (2) @(posedge sys_clk_in);
    `CHK(power_mode_out, 2'h2)
    supply_low <= 1'b1;
    repeat (250) @(posedge sys_clk_in);
    `CHK(power_mode_out, 2'h2)
    $display("test wake done");
    results();
  end
endmodule : lvdw_top_test

bind lvdw_top lvdw_top_chk lvdw_top_chk_i (.sys_clk_in, .reset_n_in, .avs_read_in,
  .avs_write_in, .avs_address_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
  .comp_low_in, .core_pc_in, .core_ack_in, .comp_enable_out, .ref_enable_out, .wake_out,
  .irq_take_out, .irq_vector_out, .power_mode_out);
